/* shared/patch_map.svh */
// Register map and constants of the ROM patch unit
`ifndef PATCH_MAP_SVH
`define PATCH_MAP_SVH
`define PATCH_ENTRIES 3
`define PATCH_ADDR_W 16
`define PATCH_DATA_W 8
`define PATCH_REG_W 4
// Register indices on the CPU register port
`define PATCH_IDX_DATA0 4'h0
`define PATCH_IDX_DATA1 4'h1
`define PATCH_IDX_DATA2 4'h2
`define PATCH_IDX_TGT0_LO 4'h3
`define PATCH_IDX_TGT0_HI 4'h4
`define PATCH_IDX_TGT1_LO 4'h5
`define PATCH_IDX_TGT1_HI 4'h6
`define PATCH_IDX_TGT2_LO 4'h7
`define PATCH_IDX_TGT2_HI 4'h8
`define PATCH_IDX_ARM 4'h9
`define PATCH_IDX_READBACK 4'ha
`define PATCH_NO_PATCH_ADDR 16'h0078
`define PATCH_ADDR_RESET 16'h0000
`define PATCH_DATA_RESET 8'h00
`define PATCH_BITS_RESET 3'h0
`define PATCH_READ_ZERO 8'h00
`endif

/* shared/patch_pkg.sv */
// Types of the ROM patch unit
package patch_pkg;
	typedef logic [15:0] addr_t;
	typedef logic [7:0] byte_t;
	typedef logic [3:0] reg_idx_t;
	typedef enum logic [1:0] {
		PROG_IDLE = 2'b00,
		PROG_WRITE = 2'b01,
		PROG_DONE = 2'b11
	} prog_state_t;
	typedef struct packed {
		addr_t [2:0] target;
		byte_t [2:0] data;
		logic [2:0] arm;
		logic [2:0] readback;
		byte_t rdata;
	} unit_state_t;
	typedef struct packed {
		prog_state_t state;
		logic [2:0] step;
		logic [1:0] entry;
		addr_t target;
		byte_t value;
		logic [2:0] arm;
		reg_idx_t idx;
		logic wr;
		byte_t wdata;
		logic done;
	} prog_regs_t;
endpackage : patch_pkg

/* shared/patch_if.sv */
// Interface between the CPU register/fetch side and the patch unit
`timescale 1ns/100ps
`default_nettype none
interface patch_if;
	logic reg_wr;
	logic reg_rd;
	logic [3:0] reg_idx;
	logic [7:0] reg_wdata;
	logic [7:0] reg_rdata;
	logic [15:0] fetch_addr;
	logic [7:0] rom_data;
	logic [7:0] fetch_data;
	logic patch_hit;
	modport unit (input reg_wr, reg_rd, reg_idx, reg_wdata, fetch_addr, rom_data,
		output reg_rdata, fetch_data, patch_hit);
	modport cpu (output reg_wr, reg_rd, reg_idx, reg_wdata, fetch_addr, rom_data,
		input reg_rdata, fetch_data, patch_hit);
endinterface : patch_if
`default_nettype wire

/* rtl/rom_patch_unit.sv */
// ROM patch unit: three address/byte entries substituting ROM reads
`timescale 1ns/100ps
`default_nettype none
`include "patch_map.svh"

module rom_patch_unit (
	input wire logic clk_sys, // System clock
	input wire logic rst, // Synchronous reset, active high
	patch_if.unit bus // CPU register port and fetch path
);
	patch_pkg::unit_state_t s_q, s_d;
	wire [2:0] hit;

	// ----------------------------------------
	// Register state
	// ----------------------------------------
	always_comb begin
		s_d = s_q;
		if (bus.reg_wr) begin
			unique case (bus.reg_idx)
				`PATCH_IDX_DATA0: s_d.data[0] = bus.reg_wdata;
				`PATCH_IDX_DATA1: s_d.data[1] = bus.reg_wdata;
				`PATCH_IDX_DATA2: s_d.data[2] = bus.reg_wdata;
				`PATCH_IDX_TGT0_LO: s_d.target[0][7:0] = bus.reg_wdata;
				`PATCH_IDX_TGT0_HI: s_d.target[0][15:8] = bus.reg_wdata;
				`PATCH_IDX_TGT1_LO: s_d.target[1][7:0] = bus.reg_wdata;
				`PATCH_IDX_TGT1_HI: s_d.target[1][15:8] = bus.reg_wdata;
				`PATCH_IDX_TGT2_LO: s_d.target[2][7:0] = bus.reg_wdata;
				`PATCH_IDX_TGT2_HI: s_d.target[2][15:8] = bus.reg_wdata;
				`PATCH_IDX_ARM: s_d.arm = bus.reg_wdata[2:0];
				`PATCH_IDX_READBACK: s_d.readback = bus.reg_wdata[2:0];
				default: ;
			endcase
		end
		// Registered read data; blocked or unmapped reads return zero
		s_d.rdata = `PATCH_READ_ZERO;
		if (bus.reg_rd) begin
			unique case (bus.reg_idx)
				`PATCH_IDX_DATA0: if (s_q.readback[0]) s_d.rdata = s_q.data[0];
				`PATCH_IDX_DATA1: if (s_q.readback[1]) s_d.rdata = s_q.data[1];
				`PATCH_IDX_DATA2: if (s_q.readback[2]) s_d.rdata = s_q.data[2];
				`PATCH_IDX_TGT0_LO: s_d.rdata = s_q.target[0][7:0];
				`PATCH_IDX_TGT0_HI: s_d.rdata = s_q.target[0][15:8];
				`PATCH_IDX_TGT1_LO: s_d.rdata = s_q.target[1][7:0];
				`PATCH_IDX_TGT1_HI: s_d.rdata = s_q.target[1][15:8];
				`PATCH_IDX_TGT2_LO: s_d.rdata = s_q.target[2][7:0];
				`PATCH_IDX_TGT2_HI: s_d.rdata = s_q.target[2][15:8];
				`PATCH_IDX_ARM: s_d.rdata = {5'h00, s_q.arm};
				`PATCH_IDX_READBACK: s_d.rdata = {5'h00, s_q.readback};
				default: ;
			endcase
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	// ----------------------------------------
	// Compare and substitute
	// ----------------------------------------
	for (genvar g = 0; g < `PATCH_ENTRIES; g++) begin : g_cmp
		assign hit[g] = s_q.arm[g] && (bus.fetch_addr == s_q.target[g])
			&& (bus.fetch_addr != `PATCH_NO_PATCH_ADDR);
	end

	always_comb begin
		bus.fetch_data = bus.rom_data;
		if (hit[0]) begin
			bus.fetch_data = s_q.data[0];
		end else if (hit[1]) begin
			bus.fetch_data = s_q.data[1];
		end else if (hit[2]) begin
			bus.fetch_data = s_q.data[2];
		end
	end

	assign bus.patch_hit = |hit;
	assign bus.reg_rdata = s_q.rdata;
endmodule : rom_patch_unit
`default_nettype wire

/* rtl/patch_programmer.sv */
// CPU-side end: programs one entry and passes fetches through
`timescale 1ns/100ps
`default_nettype none
`include "patch_map.svh"

module patch_programmer (
	input wire logic clk_sys, // System clock
	input wire logic rst, // Synchronous reset, active high
	input wire logic start, // Pulse: program entry with values below
	input wire logic [1:0] entry, // Entry 0 to 2; 3 loads read-back bits
	input wire logic [15:0] target, // Address to patch, from external store
	input wire logic [7:0] value, // Replacement byte, from external store
	output logic done, // Pulse: entry programmed and armed, or read-back bits loaded for entry 3
	input wire logic [15:0] cpu_addr, // CPU fetch address
	input wire logic [7:0] cpu_rom_data, // Built-in ROM byte
	output logic [7:0] cpu_data, // Byte seen by the CPU
	input wire logic sw_rd, // Software register read strobe
	input wire logic [3:0] sw_idx, // Software register index
	output logic [7:0] sw_rdata, // Read data, one cycle after strobe
	patch_if.cpu bus // Link to the patch unit
);
	patch_pkg::prog_regs_t r_q, r_d;

	// ----------------------------------------
	// Programming sequence
	// ----------------------------------------
	always_comb begin
		r_d = r_q;
		r_d.wr = 1'b0;
		r_d.done = 1'b0;
		unique case (r_q.state)
			patch_pkg::PROG_IDLE: begin
				if (start) begin
					r_d.state = patch_pkg::PROG_WRITE;
					// Latched so inputs may change while busy
					r_d.entry = entry;
					r_d.target = target;
					r_d.value = value;
					// Entry 3 loads the read-back test bits only
					r_d.step = (entry == 2'd3) ? 3'h4 : 3'h0;
				end
			end
			patch_pkg::PROG_WRITE: begin
				r_d.wr = 1'b1;
				r_d.step = 3'(r_q.step + 3'h1);
				unique case (r_q.step)
					3'h0: begin
						r_d.idx = 4'(`PATCH_IDX_TGT0_LO + 2 * r_q.entry);
						r_d.wdata = r_q.target[7:0];
					end
					3'h1: begin
						r_d.idx = 4'(`PATCH_IDX_TGT0_HI + 2 * r_q.entry);
						r_d.wdata = r_q.target[15:8];
					end
					3'h2: begin
						r_d.idx = 4'(`PATCH_IDX_DATA0 + r_q.entry);
						r_d.wdata = r_q.value;
					end
					3'h3: begin
						r_d.arm = r_q.arm | (3'h1 << r_q.entry);
						r_d.idx = `PATCH_IDX_ARM;
						r_d.wdata = {5'h00, r_d.arm};
						r_d.state = patch_pkg::PROG_DONE;
					end
					3'h4: begin
						r_d.idx = `PATCH_IDX_READBACK;
						r_d.wdata = {5'h00, r_q.value[2:0]};
						r_d.state = patch_pkg::PROG_DONE;
					end
					default: begin
						r_d.wr = 1'b0;
						r_d.state = patch_pkg::PROG_IDLE;
					end
				endcase
			end
			patch_pkg::PROG_DONE: begin
				r_d.done = 1'b1;
				r_d.state = patch_pkg::PROG_IDLE;
			end
			default: r_d.state = patch_pkg::PROG_IDLE;
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			r_q <= '0;
		end else begin
			r_q <= r_d;
		end
	end

	assign bus.reg_wr = r_q.wr;
	assign bus.reg_wdata = r_q.wdata;
	assign bus.reg_idx = r_q.wr ? r_q.idx : sw_idx;
	assign bus.reg_rd = sw_rd && !r_q.wr;
	assign bus.fetch_addr = cpu_addr;
	assign bus.rom_data = cpu_rom_data;
	assign cpu_data = bus.fetch_data;
	assign sw_rdata = bus.reg_rdata;
	assign done = r_q.done;
endmodule : patch_programmer
`default_nettype wire

/* bench/patch_unit_sva.sv */
// Assertion checker on the patch unit link
`timescale 1ns/100ps
`default_nettype none
module patch_unit_sva (
	input wire logic clk_sys, // Clock
	input wire logic rst, // Reset
	input wire logic reg_wr, // Write strobe
	input wire logic reg_rd, // Read strobe
	input wire logic [3:0] reg_idx, // Index
	input wire logic [7:0] reg_wdata, // Write data
	input wire logic [7:0] reg_rdata, // Read data
	input wire logic [15:0] fetch_addr, // Fetch address
	input wire logic [7:0] rom_data, // ROM byte
	input wire logic [7:0] fetch_data, // Byte to CPU
	input wire logic patch_hit // Any hit
);
	logic [2:0][15:0] t_q;
	logic [2:0][7:0] d_q;
	logic [2:0] arm_q;
	logic [2:0] rb_q;
	logic [2:0] m;
	logic [7:0] sel_d;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	// ----------
	// Shadow of the register writes
	// ----------
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			{t_q, d_q, arm_q, rb_q} <= '0;
		end else if (reg_wr) begin
			for (int i = 0; i < 3; i++) begin
				if (reg_idx == 4'(i)) d_q[i] <= reg_wdata;
				if (reg_idx == 4'(3 + 2 * i)) t_q[i][7:0] <= reg_wdata;
				if (reg_idx == 4'(4 + 2 * i)) t_q[i][15:8] <= reg_wdata;
			end
			if (reg_idx == 4'h9) arm_q <= reg_wdata[2:0];
			if (reg_idx == 4'ha) rb_q <= reg_wdata[2:0];
		end
	end
	always_comb begin
		sel_d = 8'h00;
		for (int i = 0; i < 3; i++) begin
			m[i] = arm_q[i] && t_q[i] == fetch_addr && fetch_addr != 16'h0078;
		end
		if (reg_idx < 4'h3) sel_d = d_q[reg_idx[1:0]];
	end
	// ----------
	// Properties
	// ----------
	property p_fixed; fetch_addr == 16'h0078 |-> !patch_hit && fetch_data == rom_data; endproperty
	a_fixed: assert property (p_fixed) else $error("fixed address patched");
	property p_hit; patch_hit == (m != 3'h0); endproperty
	a_hit: assert property (p_hit) else $error("hit flag wrong");
	property p_miss; !patch_hit |-> fetch_data == rom_data; endproperty
	a_miss: assert property (p_miss) else $error("miss not passed");
	property p_e0; m[0] |-> fetch_data == d_q[0]; endproperty
	a_e0: assert property (p_e0) else $error("entry 0 byte wrong");
	property p_e1; m[1:0] == 2'b10 |-> fetch_data == d_q[1]; endproperty
	a_e1: assert property (p_e1) else $error("entry 1 byte wrong");
	property p_e2; m == 3'b100 |-> fetch_data == d_q[2]; endproperty
	a_e2: assert property (p_e2) else $error("entry 2 byte wrong");
	property p_gate; reg_rd && reg_idx < 4'h3 && !rb_q[reg_idx[1:0]] |=> reg_rdata == 8'h00; endproperty
	a_gate: assert property (p_gate) else $error("gated read leaked");
	property p_arm; reg_rd && reg_idx == 4'h9 |=> reg_rdata == {5'h00, $past(arm_q)}; endproperty
	a_arm: assert property (p_arm) else $error("arm read wrong");
	property p_unmap; reg_rd && reg_idx > 4'ha |=> reg_rdata == 8'h00; endproperty
	a_unmap: assert property (p_unmap) else $error("unmapped read nonzero");
	property p_rbdata; reg_rd && reg_idx < 4'h3 && rb_q[reg_idx[1:0]] |=> reg_rdata == $past(sel_d); endproperty
	a_rbdata: assert property (p_rbdata) else $error("enabled data read wrong");
	property p_rbreg; reg_rd && reg_idx == 4'ha |=> reg_rdata == {5'h00, $past(rb_q)}; endproperty
	a_rbreg: assert property (p_rbreg) else $error("read-back bits read wrong");
endmodule : patch_unit_sva
`default_nettype wire

/* bench/testbench.sv */
// Testbench joining the patch unit and programmer
`timescale 1ns/100ps
`default_nettype none
module testbench;
	logic clk_sys = 0, rst = 1, start = 0, done, sw_rd = 0;
	logic [1:0] entry = 2'h0;
	logic [15:0] target = 16'h0000, cpu_addr = 16'h0000;
	logic [7:0] value = 8'h00, cpu_data, sw_rdata;
	logic [3:0] sw_idx = 4'h0;
	int error_cnt = 0, n_tests = 0;
	patch_if u_patch_if ();
	rom_patch_unit u_rom_patch_unit (.clk_sys(clk_sys), .rst(rst), .bus(u_patch_if.unit));
	patch_programmer u_patch_programmer (.clk_sys(clk_sys), .rst(rst), .start(start),
		.entry(entry), .target(target), .value(value), .done(done), .cpu_addr(cpu_addr),
		.cpu_rom_data(~cpu_addr[7:0]), .cpu_data(cpu_data), .sw_rd(sw_rd), .sw_idx(sw_idx),
		.sw_rdata(sw_rdata), .bus(u_patch_if.cpu));
	patch_unit_sva u_sva (.clk_sys(clk_sys), .rst(rst), .reg_wr(u_patch_if.reg_wr),
		.reg_rd(u_patch_if.reg_rd), .reg_idx(u_patch_if.reg_idx),
		.reg_wdata(u_patch_if.reg_wdata), .reg_rdata(u_patch_if.reg_rdata),
		.fetch_addr(u_patch_if.fetch_addr), .rom_data(u_patch_if.rom_data),
		.fetch_data(u_patch_if.fetch_data), .patch_hit(u_patch_if.patch_hit));
	initial forever #5 clk_sys = ~clk_sys;
	task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic prog(input logic [1:0] e, input logic [15:0] t, input logic [7:0] v);
		int n = 0;
		@(negedge clk_sys);
		{start, entry, target, value} = {1'b1, e, t, v};
		@(negedge clk_sys);
		start = 0;
		while (done !== 1'b1 && n < 20) begin
			@(posedge clk_sys);
			#1;
			n++;
		end
		chk("done", 8'(n), (e == 2'h3) ? 8'h02 : 8'h05);
	endtask : prog
	task automatic fetch(input logic [15:0] a, input logic [7:0] exp, input logic hit);
		@(negedge clk_sys);
		cpu_addr = a;
		#1;
		chk("fetch", cpu_data, exp);
		chk("hit", {7'h00, u_patch_if.patch_hit}, {7'h00, hit});
	endtask : fetch
	task automatic rd(input logic [3:0] i, input logic [7:0] exp);
		@(negedge clk_sys);
		{sw_rd, sw_idx} = {1'b1, i};
		@(negedge clk_sys);
		sw_rd = 0;
		chk("rdata", sw_rdata, exp);
	endtask : rd
	task automatic t_reset;
		fetch(16'h0000, 8'hff, 1'b0);
		rd(4'h0, 8'h00);
		rd(4'h9, 8'h00);
	endtask : t_reset
	task automatic t_single;
		prog(2'h0, 16'hf011, 8'hb5);
		fetch(16'hf011, 8'hb5, 1'b1);
		fetch(16'hf012, 8'hed, 1'b0);
		rd(4'h0, 8'h00);
	endtask : t_single
	task automatic t_multi;
		prog(2'h1, 16'h1234, 8'h5a);
		prog(2'h2, 16'h0078, 8'h77);
		fetch(16'h1234, 8'h5a, 1'b1);
		fetch(16'hf011, 8'hb5, 1'b1);
		fetch(16'h0078, 8'h87, 1'b0);
		rd(4'h9, 8'h07);
		rd(4'hf, 8'h00);
	endtask : t_multi
	task automatic t_dup;
		prog(2'h2, 16'h1234, 8'h99);
		fetch(16'h1234, 8'h5a, 1'b1);
		prog(2'h1, 16'h4444, 8'h11);
		fetch(16'h1234, 8'h99, 1'b1);
		fetch(16'h4444, 8'h11, 1'b1);
	endtask : t_dup
	task automatic t_rerst;
		prog(2'h3, 16'h0000, 8'h05);
		rd(4'h0, 8'hb5);
		rd(4'h1, 8'h00);
		rd(4'h2, 8'h99);
		rd(4'ha, 8'h05);
		rd(4'h5, 8'h44);
		@(negedge clk_sys);
		rst = 1;
		repeat (2) @(negedge clk_sys);
		rst = 0;
		fetch(16'h4444, 8'hbb, 1'b0);
		rd(4'h5, 8'h00);
		rd(4'ha, 8'h00);
		rd(4'h9, 8'h00);
		prog(2'h3, 16'h0000, 8'h07);
		rd(4'h2, 8'h00);
	endtask : t_rerst
	task automatic end_sim;
		$display("errors %0d tests %0d", error_cnt, n_tests);
		if (error_cnt == 0 && n_tests > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : end_sim
	initial begin
		repeat (10) @(negedge clk_sys);
		rst = 0;
		t_reset();
		t_single();
		t_multi();
		t_dup();
		t_rerst();
		end_sim();
	end
	initial begin
		repeat (3000) @(posedge clk_sys);
		error_cnt++;
		end_sim();
	end
endmodule : testbench
`default_nettype wire
